/* design/adc_seq_pkg.sv */
// constants, types and helpers shared by the converter sequencer files
package adc_seq_pkg;

  // ==========================================================
  // clocks and rates
  localparam int REF_CLK_HZ = 100_000_000;
  localparam int SRC_CLK_HZ = 16_000_000;
  // ref_clk cycles per converter clock at the fastest rate (src / 8)
  localparam int CONV_DIV_BASE = REF_CLK_HZ / (SRC_CLK_HZ / 8);
  localparam int DIV_CNT_W = 9;
  localparam logic [5:0] CONV_EXTRA_TICKS = 6'h0d;

  // ==========================================================
  // widths
  localparam int RES_W = 10;
  localparam int ACC_W = 14;
  localparam int WORD_W = 16;
  localparam int LEN_W = 11;
  localparam int NUM_CH = 8;
  localparam logic [2:0] TEMP_CH = 3'h6;
  localparam logic [2:0] SUPPLY_CH = 3'h7;
  localparam logic [RES_W-1:0] SAR_FIRST = 10'h200;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_EN = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_ACCUM = 8'h10;
  localparam logic [7:0] OFS_BUF_BASE = 8'h14;
  localparam logic [7:0] OFS_BUF_LEN = 8'h18;
  localparam logic [7:0] OFS_TIMER = 8'h1c;
  localparam logic [7:0] OFS_CH_MASK = 8'h20;
  localparam logic [7:0] OFS_BUF_PTR = 8'h24;

  // control register fields
  localparam int CTRL_W = 18;
  localparam int CTRL_START = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_CHAN = 3;
  localparam int CTRL_DIV = 6;
  localparam int CTRL_SMP = 8;
  localparam int CTRL_GAIN = 10;
  localparam int CTRL_EXTREF = 11;
  localparam int CTRL_ACC_EN = 12;
  localparam int CTRL_ACC_N = 13;
  localparam int CTRL_DEFER = 15;
  localparam int CTRL_BUF = 16;
  localparam int CTRL_WRAP = 17;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 18'h00000;

  // status register fields
  localparam int EV_W = 4;
  localparam int ST_EOC = 0;
  localparam int ST_HALF = 1;
  localparam int ST_FULL = 2;
  localparam int ST_OVF = 3;
  localparam int ST_BUSY = 4;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_DMA = 4'b1000
  } conv_state_t;

  typedef struct packed {
    logic active;
    logic sample;
    logic [2:0] chan;
    logic [RES_W-1:0] dac;
    logic gain;
    logic ext_ref;
    logic supply_div_en;
  } ana_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } dma_req_t;

  // ==========================================================
  // sampling window in converter clocks: 2, 4, 6 or 8
  function automatic logic [5:0] sample_ticks(input logic [1:0] sel);
    sample_ticks = {3'h0, sel, 1'b0} + 6'h02;
  endfunction

  // conversion remainder after the window: two more windows plus 13
  function automatic logic [5:0] convert_ticks(input logic [1:0] sel);
    logic [5:0] win;
    win = sample_ticks(sel);
    convert_ticks = {win[4:0], 1'b0} + CONV_EXTRA_TICKS;
  endfunction

endpackage

/* design/adc_sequencer.sv */
// converter sequencer: APB registers, SAR control, accumulator, DMA ring
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog front end
  input wire logic cmp_in,
  output adc_seq_pkg::ana_ctrl_t ana,
  // dma write port
  output adc_seq_pkg::dma_req_t dma,
  input wire logic dma_ack,
  // interrupt
  output logic irq
);
  localparam int RES_W = adc_seq_pkg::RES_W;
  localparam int ACC_W = adc_seq_pkg::ACC_W;
  localparam int LEN_W = adc_seq_pkg::LEN_W;
  localparam int EV_W = adc_seq_pkg::EV_W;

  // ==========================================================
  // helpers

  // lowest selected input of a scan mask
  function automatic logic [2:0] first_chan(input logic [7:0] m);
    first_chan = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        first_chan = 3'(i);
      end
    end
  endfunction

  // ==========================================================
  // register storage
  logic [adc_seq_pkg::CTRL_W-1:0] ctrl;
  logic [adc_seq_pkg::CTRL_W-1:0] next_ctrl;
  logic [EV_W-1:0] int_en;
  logic [EV_W-1:0] next_int_en;
  logic [15:0] buf_base;
  logic [15:0] next_buf_base;
  logic [LEN_W-1:0] buf_len;
  logic [LEN_W-1:0] next_buf_len;
  logic [15:0] period;
  logic [15:0] next_period;
  logic [7:0] ch_mask;
  logic [7:0] next_ch_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic wr_now;
  logic start_pulse;
  logic [EV_W-1:0] clr_ev;

  // ==========================================================
  // conversion state
  adc_seq_pkg::conv_state_t state;
  adc_seq_pkg::conv_state_t next_state;
  logic [5:0] tcnt;
  logic [5:0] next_tcnt;
  logic [RES_W-1:0] dac;
  logic [RES_W-1:0] next_dac;
  logic [RES_W-1:0] sar_bit;
  logic [RES_W-1:0] next_sar_bit;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] next_result;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [3:0] acc_cnt;
  logic [3:0] next_acc_cnt;
  logic [7:0] scan;
  logic [7:0] next_scan;
  logic [2:0] chan;
  logic [2:0] next_chan;
  logic [LEN_W-1:0] ptr;
  logic [LEN_W-1:0] next_ptr;
  logic buf_full;
  logic next_buf_full;
  logic [15:0] timer;
  logic [15:0] next_timer;
  logic pend;
  logic next_pend;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] set_ev;
  adc_seq_pkg::dma_req_t next_dma;
  adc_seq_pkg::ana_ctrl_t next_ana;
  logic next_irq;
  logic tick;
  logic start_conv;
  logic trigger;
  logic buf_mode;
  logic acc_last;
  logic [LEN_W-1:0] ptr_inc;

  assign buf_mode = ctrl[adc_seq_pkg::CTRL_BUF];

  // ==========================================================
  // converter clock enable
  conv_clock_div u_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .run(state != adc_seq_pkg::ST_IDLE),
    .div_sel(ctrl[adc_seq_pkg::CTRL_DIV +: 2]),
    .tick(tick)
  );

  // ==========================================================
  // apb slave: one wait state, write lands on the ready edge
  always_comb begin
    next_ctrl = ctrl;
    next_int_en = int_en;
    next_buf_base = buf_base;
    next_buf_len = buf_len;
    next_period = period;
    next_ch_mask = ch_mask;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    start_pulse = 1'b0;
    clr_ev = '0;
    next_pready = psel && penable && !pready;
    wr_now = psel && penable && pready && pwrite;
    // read data and error are captured as ready rises
    if (next_pready) begin
      next_prdata = 32'h00000000;
      if (paddr == adc_seq_pkg::OFS_CTRL) begin
        next_prdata[adc_seq_pkg::CTRL_W-1:0] = ctrl;
      end else if (paddr == adc_seq_pkg::OFS_STATUS) begin
        next_prdata[EV_W:0] = {state != adc_seq_pkg::ST_IDLE, status};
      end else if (paddr == adc_seq_pkg::OFS_INT_EN) begin
        next_prdata[EV_W-1:0] = int_en;
      end else if (paddr == adc_seq_pkg::OFS_RESULT) begin
        next_prdata[RES_W-1:0] = result;
      end else if (paddr == adc_seq_pkg::OFS_ACCUM) begin
        next_prdata[ACC_W-1:0] = acc;
      end else if (paddr == adc_seq_pkg::OFS_BUF_BASE) begin
        next_prdata[15:0] = buf_base;
      end else if (paddr == adc_seq_pkg::OFS_BUF_LEN) begin
        next_prdata[LEN_W-1:0] = buf_len;
      end else if (paddr == adc_seq_pkg::OFS_TIMER) begin
        next_prdata[15:0] = period;
      end else if (paddr == adc_seq_pkg::OFS_CH_MASK) begin
        next_prdata[7:0] = ch_mask;
      end else if (paddr == adc_seq_pkg::OFS_BUF_PTR) begin
        next_prdata[LEN_W:0] = {buf_full, ptr};
      end else begin
        next_pslverr = 1'b1;
      end
    end
    // register writes
    if (wr_now) begin
      if (paddr == adc_seq_pkg::OFS_CTRL) begin
        next_ctrl = pwdata[adc_seq_pkg::CTRL_W-1:0];
        next_ctrl[adc_seq_pkg::CTRL_START] = 1'b0;
        start_pulse = pwdata[adc_seq_pkg::CTRL_START];
      end else if (paddr == adc_seq_pkg::OFS_STATUS) begin
        clr_ev = pwdata[EV_W-1:0]; // write one to clear
      end else if (paddr == adc_seq_pkg::OFS_INT_EN) begin
        next_int_en = pwdata[EV_W-1:0];
      end else if (paddr == adc_seq_pkg::OFS_BUF_BASE) begin
        next_buf_base = {pwdata[15:1], 1'b0}; // word aligned
      end else if (paddr == adc_seq_pkg::OFS_BUF_LEN) begin
        next_buf_len = pwdata[LEN_W-1:0];
      end else if (paddr == adc_seq_pkg::OFS_TIMER) begin
        next_period = pwdata[15:0];
      end else if (paddr == adc_seq_pkg::OFS_CH_MASK) begin
        next_ch_mask = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= adc_seq_pkg::CTRL_RESET;
      int_en <= '0;
      buf_base <= '0;
      buf_len <= '0;
      period <= '0;
      ch_mask <= '0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      int_en <= next_int_en;
      buf_base <= next_buf_base;
      buf_len <= next_buf_len;
      period <= next_period;
      ch_mask <= next_ch_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // conversion, accumulation and buffer sequencing
  always_comb begin
    next_state = state;
    next_tcnt = tcnt;
    next_dac = dac;
    next_sar_bit = sar_bit;
    next_result = result;
    next_acc = acc;
    next_acc_cnt = acc_cnt;
    next_scan = scan;
    next_chan = chan;
    next_ptr = ptr;
    next_buf_full = buf_full;
    next_dma = dma;
    set_ev = '0;
    start_conv = 1'b0;
    trigger = 1'b0;
    ptr_inc = ptr + 11'h001;
    acc_last = acc_cnt == 4'((5'h02 << ctrl[adc_seq_pkg::CTRL_ACC_N +: 2]) - 5'h01);
    // sampling timer, counts ref_clk cycles
    next_timer = '0;
    if (buf_mode) begin
      if (timer >= period) begin
        trigger = 1'b1;
      end else begin
        next_timer = timer + 16'h0001;
      end
    end else begin
      next_ptr = '0;
      next_buf_full = 1'b0;
      next_scan = '0;
    end
    if (trigger && scan == 8'h00 && state == adc_seq_pkg::ST_IDLE) begin
      next_scan = ch_mask;
    end
    case (state)
      adc_seq_pkg::ST_IDLE: begin
        if (buf_mode) begin
          if (scan != 8'h00) begin
            next_chan = first_chan(scan);
            start_conv = 1'b1;
          end
        end else if (pend || ctrl[adc_seq_pkg::CTRL_CONT]) begin
          next_chan = ctrl[adc_seq_pkg::CTRL_CHAN +: 3];
          start_conv = 1'b1;
        end
        if (start_conv) begin
          next_state = adc_seq_pkg::ST_SAMPLE;
          next_tcnt = '0;
        end
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (tick) begin
          // hold after the programmed window
          if (tcnt == adc_seq_pkg::sample_ticks(ctrl[adc_seq_pkg::CTRL_SMP +: 2]) - 6'h01) begin
            next_state = adc_seq_pkg::ST_CONVERT;
            next_tcnt = '0;
            next_dac = adc_seq_pkg::SAR_FIRST;
            next_sar_bit = adc_seq_pkg::SAR_FIRST;
          end else begin
            next_tcnt = tcnt + 6'h01;
          end
        end
      end
      adc_seq_pkg::ST_CONVERT: begin
        if (tick) begin
          next_tcnt = tcnt + 6'h01;
          // one bit decided per converter clock, msb first
          if (sar_bit != '0) begin
            next_dac = (cmp_in ? dac : (dac & ~sar_bit)) | (sar_bit >> 1);
            next_sar_bit = sar_bit >> 1;
          end
          if (tcnt == adc_seq_pkg::convert_ticks(ctrl[adc_seq_pkg::CTRL_SMP +: 2]) - 6'h01) begin
            next_result = dac;
            // raw running sum, first sample restarts it
            if (ctrl[adc_seq_pkg::CTRL_ACC_EN]) begin
              next_acc = (acc_cnt == 4'h0 ? '0 : acc) + ACC_W'(dac);
              next_acc_cnt = acc_last ? 4'h0 : acc_cnt + 4'h1;
            end else begin
              next_acc_cnt = 4'h0;
            end
            if (!(ctrl[adc_seq_pkg::CTRL_ACC_EN] && ctrl[adc_seq_pkg::CTRL_DEFER])
                || acc_last) begin
              set_ev[adc_seq_pkg::ST_EOC] = 1'b1;
            end
            next_state = adc_seq_pkg::ST_IDLE;
            if (buf_mode) begin
              next_scan = scan & ~(8'h01 << chan);
              if (buf_full) begin
                set_ev[adc_seq_pkg::ST_OVF] = 1'b1;
              end else begin
                next_dma.valid = 1'b1;
                next_dma.addr = buf_base + {4'h0, ptr, 1'b0};
                next_dma.data = {6'h00, dac};
                next_state = adc_seq_pkg::ST_DMA;
              end
            end
          end
        end
      end
      adc_seq_pkg::ST_DMA: begin
        // next conversion waits for the ram write
        if (dma_ack) begin
          next_dma.valid = 1'b0;
          next_state = adc_seq_pkg::ST_IDLE;
          next_ptr = ptr_inc;
          if (ptr_inc == (buf_len >> 1)) begin
            set_ev[adc_seq_pkg::ST_HALF] = 1'b1;
          end
          if (ptr_inc >= buf_len) begin
            set_ev[adc_seq_pkg::ST_FULL] = 1'b1;
            if (ctrl[adc_seq_pkg::CTRL_WRAP]) begin
              next_ptr = '0;
            end else begin
              next_buf_full = 1'b1;
            end
          end
        end
      end
      default: begin
        next_state = adc_seq_pkg::ST_IDLE;
      end
    endcase
    // single request waits until a conversion takes it
    next_pend = (pend && !start_conv) || (start_pulse && !buf_mode);
    // a new event wins over a clear in the same cycle
    next_status = (status & ~clr_ev) | set_ev;
    next_irq = |(next_status & int_en);
    // analog controls follow the next state
    next_ana.active = next_state == adc_seq_pkg::ST_SAMPLE
      || next_state == adc_seq_pkg::ST_CONVERT;
    next_ana.sample = next_state == adc_seq_pkg::ST_SAMPLE;
    next_ana.chan = next_chan;
    next_ana.dac = next_dac;
    next_ana.gain = ctrl[adc_seq_pkg::CTRL_GAIN];
    next_ana.ext_ref = ctrl[adc_seq_pkg::CTRL_EXTREF];
    next_ana.supply_div_en = next_ana.active
      && next_chan == adc_seq_pkg::SUPPLY_CH;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= adc_seq_pkg::ST_IDLE;
      tcnt <= '0;
      dac <= '0;
      sar_bit <= '0;
      result <= '0;
      acc <= '0;
      acc_cnt <= '0;
      scan <= '0;
      chan <= '0;
      ptr <= '0;
      buf_full <= 1'b0;
      timer <= '0;
      pend <= 1'b0;
      status <= '0;
      dma <= '0;
      ana <= '0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      tcnt <= next_tcnt;
      dac <= next_dac;
      sar_bit <= next_sar_bit;
      result <= next_result;
      acc <= next_acc;
      acc_cnt <= next_acc_cnt;
      scan <= next_scan;
      chan <= next_chan;
      ptr <= next_ptr;
      buf_full <= next_buf_full;
      timer <= next_timer;
      pend <= next_pend;
      status <= next_status;
      dma <= next_dma;
      ana <= next_ana;
      irq <= next_irq;
    end
  end
endmodule // adc_sequencer
`default_nettype wire

/* design/conv_clock_div.sv */
// converter clock divider: one-cycle enable at 2 MHz, 1 MHz, 500 kHz or 250 kHz
`timescale 1ns/1ps
`default_nettype none
module conv_clock_div (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [1:0] div_sel,
  // enable out
  output logic tick
);
  localparam int DIV_CNT_W = adc_seq_pkg::DIV_CNT_W;
  localparam logic [DIV_CNT_W-1:0] BASE =
    DIV_CNT_W'(adc_seq_pkg::CONV_DIV_BASE);

  logic [DIV_CNT_W-1:0] cnt;
  logic [DIV_CNT_W-1:0] next_cnt;
  logic next_tick;
  logic [DIV_CNT_W-1:0] limit;

  // count to base << sel, pulse at the wrap
  always_comb begin
    limit = DIV_CNT_W'(BASE << div_sel) - 9'h001;
    next_tick = 1'b0;
    next_cnt = cnt + 9'h001;
    if (!run) begin
      next_cnt = '0;
    end else if (cnt == limit) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule // conv_clock_div
`default_nettype wire

/* verification/adc_sequencer_assertions.sv */
// concurrent checks on the converter sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // front end and dma
  input wire adc_seq_pkg::ana_ctrl_t ana,
  input wire adc_seq_pkg::dma_req_t dma,
  input wire logic dma_ack
);
  // ==========================================================
  // properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence access_begins;
    $rose(psel && penable);
  endsequence
  sequence one_wait_state;
    !pready ##1 pready;
  endsequence
  pready_wait_a: assert property (access_begins |-> one_wait_state)
    else $error("pready not in second access cycle");
  pready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  dma_hold_a: assert property (dma.valid && !dma_ack |=> dma.valid && $stable(dma))
    else $error("dma request changed before ack");
  dma_release_a: assert property ($fell(dma.valid) |-> $past(dma_ack))
    else $error("dma request dropped without ack");
  dma_word_a: assert property (dma.valid |-> dma.data[15:10] == 6'h00 && !dma.addr[0])
    else $error("dma word not right-justified");
  supply_div_a: assert property (ana.supply_div_en == (ana.active && ana.chan == 3'h7))
    else $error("supply divider enabled wrongly");
  sample_first_a: assert property ($rose(ana.active) |-> ana.sample)
    else $error("conversion did not begin with sampling");
  hold_trial_a: assert property (ana.active && $fell(ana.sample) |-> ##[0:1] ana.dac == 10'h200)
    else $error("hold did not start at mid-scale trial");
endmodule // adc_sequencer_assertions
bind adc_sequencer adc_sequencer_assertions u_adc_sequencer_assertions (.ref_clk(ref_clk),
  .resetn(resetn), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ana(ana), .dma(dma), .dma_ack(dma_ack));
`default_nettype wire

/* verification/analog_dma_model.sv */
// ideal comparator on per-channel levels and a stalling dma memory port
`timescale 1ns/1ps
`default_nettype none
module analog_dma_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // converter side
  input wire adc_seq_pkg::ana_ctrl_t ana,
  input wire logic [9:0] lvl [8],
  output logic cmp_in,
  // dma side
  input wire adc_seq_pkg::dma_req_t dma,
  output logic dma_ack
);
  logic [1:0] stall;
  logic flip;
  // comparator only meaningful while converting; otherwise a changing pattern
  assign cmp_in = ana.active ? (lvl[ana.chan] >= ana.dac) : flip;
  // ack after a random stall of 0..3 cycles, one cycle long
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dma_ack <= 1'b0;
      stall <= 2'h0;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      if (dma.valid && !dma_ack) begin
        if (stall == 2'h0) begin
          dma_ack <= 1'b1;
          stall <= 2'($urandom_range(3, 0));
        end else
          stall <= stall - 2'h1;
      end else
        dma_ack <= 1'b0;
    end
  end
endmodule // analog_dma_model
`default_nettype wire

/* verification/tb_adc_sequencer.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequencer;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, cmp_in, dma_ack, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] lvl [8];
  adc_seq_pkg::ana_ctrl_t ana;
  adc_seq_pkg::dma_req_t dma;
  logic [33:0] exp_rd [$];
  logic [31:0] exp_dma [$];
  logic [31:0] exp_t [$];
  int fails = 0, comparisons = 0, act = 0, cyc = 0;
  logic [31:0] q;
  adc_sequencer u_adc_sequencer (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp_in(cmp_in), .ana(ana), .dma(dma),
    .dma_ack(dma_ack), .irq(irq));
  analog_dma_model u_analog_dma_model (.ref_clk(ref_clk), .resetn(resetn), .ana(ana),
    .lvl(lvl), .cmp_in(cmp_in), .dma(dma), .dma_ack(dma_ack));
  // ==========================================================
  // helpers
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic cmp(input logic [63:0] s, input logic [63:0] x);
    comparisons++;
    if (s !== x) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task tally_and_finish;
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one apb transfer; e = {compare, error, data} noted for the watcher
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e, output logic [31:0] rq);
    exp_rd.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rq;
    apb(1'b1, a, d, 34'h0, rq);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] rq;
    apb(1'b0, a, 32'h0, {2'b10, x}, rq);
  endtask
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    logic [31:0] rq;
    for (int k = 0; k < 5000; k++) begin
      apb(1'b0, a, 32'h0, 34'h0, rq);
      if (rq[b] === v) break;
    end
    cmp(rq[b], v);
  endtask
  // ==========================================================
  // watcher: takes the oldest note whenever a result shows
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      tally_and_finish;
    end
    if (psel && penable && pready) begin
      if (exp_rd[0][33]) cmp({pslverr, prdata}, exp_rd[0][32:0]);
      void'(exp_rd.pop_front());
    end
    if (dma.valid && dma_ack) begin
      if (exp_dma.size() == 0) cmp(1'b0, 1'b1);
      else cmp({dma.addr, dma.data}, exp_dma.pop_front());
    end
    if (ana.active && act == 0 && exp_t.size() != 0)
      cmp({ana.gain, ana.ext_ref}, exp_t[0][31:30]);
    if (ana.active) act++;
    else if (act != 0) begin
      if (exp_t.size() != 0)
        cmp(act >= exp_t[0][29:0] && act <= exp_t[0][29:0] + 3, 1);
      if (exp_t.size() != 0) void'(exp_t.pop_front());
      act = 0;
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    resetn = 1'b0;
    void'($urandom(99941));
    foreach (lvl[i]) lvl[i] = 10'($urandom);
    lvl[0] = 10'h3ff;
    lvl[1] = 10'h000;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    r(8'h00, 32'h0);
    r(8'h04, 32'h0);
    apb(1'b0, 8'h28, 32'h0, {2'b11, 32'h0}, q);
    w(8'h08, 32'h1);
    // single shots: every channel, divider and window, gain and reference
    for (int i = 0; i < 8; i++) begin
      int dv, sm;
      dv = (i < 4) ? i : 0;
      sm = (i < 4) ? 0 : i - 4;
      exp_t.push_back({i[0], i[1], 30'((6 * sm + 19) * (50 << dv))});
      w(8'h00, 32'(2 | i << 3 | dv << 6 | sm << 8 | (i & 3) << 10));
      wait_bit(8'h04, 0, 1'b1);
      cmp(irq, 1'b1);
      r(8'h0c, {22'h0, lvl[i]});
      r(8'h04, 32'h1);
      w(8'h04, 32'h1);
      cmp(irq, 1'b0);
    end
    // continuous accumulation with deferred completion, 2..16 samples
    for (int n = 0; n < 4; n++) begin
      w(8'h00, 32'(4 | 3 << 3 | 1 << 12 | n << 13 | 1 << 15));
      wait_bit(8'h04, 0, 1'b1);
      r(8'h10, 32'((2 << n) * lvl[3]));
      r(8'h0c, {22'h0, lvl[3]});
      w(8'h00, 32'h0);
      wait_bit(8'h04, 4, 1'b0);
      w(8'h04, 32'h1);
    end
    // buffer mode without wrap: fill, then overflow
    w(8'h14, 32'h100);
    w(8'h18, 32'h4);
    w(8'h20, 32'h85);
    w(8'h1c, 32'd3999);
    w(8'h08, 32'h8);
    exp_dma = '{{16'h100, 6'h0, lvl[0]}, {16'h102, 6'h0, lvl[2]}, {16'h104, 6'h0, lvl[7]},
                {16'h106, 6'h0, lvl[0]}};
    w(8'h00, 32'h10000);
    wait_bit(8'h04, 3, 1'b1);
    cmp(exp_dma.size(), 0);
    cmp(irq, 1'b1);
    apb(1'b0, 8'h04, 32'h0, 34'h0, q);
    cmp(q[3:1], 3'h7);
    w(8'h04, 32'h8);
    cmp(irq, 1'b0);
    w(8'h00, 32'h0);
    wait_bit(8'h04, 4, 1'b0);
    w(8'h04, 32'hf);
    // buffer mode with wrap: pointer returns to the start
    exp_dma = '{{16'h100, 6'h0, lvl[0]}, {16'h102, 6'h0, lvl[2]}, {16'h104, 6'h0, lvl[7]},
                {16'h106, 6'h0, lvl[0]}, {16'h100, 6'h0, lvl[2]}, {16'h102, 6'h0, lvl[7]}};
    w(8'h00, 32'h30000);
    for (int k = 0; k < 20000 && exp_dma.size() != 0; k++) @(posedge ref_clk);
    cmp(exp_dma.size(), 0);
    w(8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0, 34'h0, q);
    cmp(q[3], 1'b0);
    tally_and_finish;
  end
endmodule // tb_adc_sequencer
`default_nettype wire
